//--- core/rcrs_sequencer.v
// How it works
// - call saves the linkage register on the stack, then loads return address
// - return pops stack into linkage register, resumes at the held return address
// - call entered on branch_to_control_store to word 1 of microstore page 1
// - word after the calling instruction is the subroutine address
// - return entered on branch_to_control_store to word 2 of microstore page 1
// - push decrements stack pointer, then stores linkage at the new value
// - pop reads linkage at current stack pointer, then increments it
// - store holds data on ALU output, stalls until memory_done; memory time varies
// - saved return address is program counter plus one
// - call restarts pipeline by fetching at address held in memory_input_reg
// - last call step loads PC, fetches next word, page_jump to decode_state
// - first return step fetches at return address and restores the PC
// - second step fetches saved linkage; third increments SP and fetches at PC+1
// - last return step loads linkage from memory_input_reg, decode-jumps to page 0
// - first call step decrements SP, starts the linkage store, branches onward
`timescale 1ns/1ps
`include "rcrs_map.vh"
module rcrs_sequencer #(
  parameter WIDTH = 16
) (
  // clock and reset
  input wire clk_in,
  input wire resetn_in,
  // branch_to_control_store dispatch
  input wire bcs_valid_in,
  input wire [3:0] bcs_page_in,
  input wire [4:0] bcs_word_in,
  // processor state loaded at dispatch
  input wire [WIDTH-1:0] pc_in,
  input wire [WIDTH-1:0] stack_pointer_reg_in,
  input wire [WIDTH-1:0] linkage_reg_in,
  // memory subsystem
  input wire [WIDTH-1:0] memory_input_reg_in,
  input wire memory_done_in,
  output reg [1:0] mem_req_out,
  output reg [WIDTH-1:0] mem_addr_out,
  output reg [WIDTH-1:0] alu_out,
  // register results
  output reg [WIDTH-1:0] pc_out,
  output reg [WIDTH-1:0] stack_pointer_reg_out,
  output reg [WIDTH-1:0] linkage_reg_out,
  // control handback
  output reg busy_out,
  output reg page_jump_out,
  output reg [3:0] page_jump_page_out,
  output reg [7:0] page_jump_state_out,
  output reg decode_jump_out
);
  localparam S_IDLE = 3'd0;
  localparam S_CALL_WAIT = 3'd1;
  localparam S_CALL_LINK = 3'd2;
  localparam S_CALL_FETCH = 3'd3;
  localparam S_RET_FETCH = 3'd4;
  localparam S_RET_STEP3 = 3'd5;
  localparam S_RET_LOAD = 3'd6;

  reg [2:0] state;
  reg [2:0] next_state;
  wire mem_done;

  // memory completion is asynchronous to the microcycle
  rcrs_sync u_done_sync (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .d_in(memory_done_in),
    .q_out(mem_done)
  );

  function is_target;
    input [3:0] page;
    input [4:0] word;
    input [3:0] want_page;
    input [4:0] want_word;
    begin
      is_target = (page == want_page) && (word == want_word);
    end
  endfunction

  wire hit_call = bcs_valid_in && is_target(bcs_page_in, bcs_word_in, `RCRS_CALL_PAGE, `RCRS_CALL_WORD);
  wire hit_ret = bcs_valid_in && is_target(bcs_page_in, bcs_word_in, `RCRS_RET_PAGE, `RCRS_RET_WORD);
  // one step up or down; truncation to WIDTH gives the modulo wrap
  function [WIDTH-1:0] step_one;
    input [WIDTH-1:0] value;
    input up;
    begin
      if (up) begin
        step_one = value + {{(WIDTH-1){1'b0}}, 1'b1};
      end else begin
        step_one = value - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  endfunction

  wire [WIDTH-1:0] sp_dec = step_one(stack_pointer_reg_in, 1'b0);
  wire [WIDTH-1:0] sp_inc = step_one(stack_pointer_reg_out, 1'b1);
  wire [WIDTH-1:0] pc_plus = step_one(pc_out, 1'b1);
  wire [WIDTH-1:0] mir_plus = step_one(memory_input_reg_in, 1'b1);

  // sequencing kept apart from the datapath so every stall reads in one place
  always @* begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (hit_call) begin
          next_state = S_CALL_WAIT;
        end else if (hit_ret) begin
          next_state = S_RET_FETCH;
        end
      end
      S_CALL_WAIT: begin
        if (mem_done) begin
          next_state = S_CALL_LINK;
        end
      end
      S_CALL_LINK: begin
        next_state = S_CALL_FETCH;
      end
      S_CALL_FETCH: begin
        next_state = S_IDLE;
      end
      S_RET_FETCH: begin
        next_state = S_RET_STEP3;
      end
      S_RET_STEP3: begin
        next_state = S_RET_LOAD;
      end
      S_RET_LOAD: begin
        // read data is only trusted once memory says it landed
        if (mem_done) begin
          next_state = S_IDLE;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= S_IDLE;
      mem_req_out <= `RCRS_REQ_NONE;
      mem_addr_out <= {WIDTH{1'b0}};
      alu_out <= {WIDTH{1'b0}};
      pc_out <= `RCRS_PC_RESET;
      stack_pointer_reg_out <= `RCRS_SP_RESET;
      linkage_reg_out <= `RCRS_LINK_RESET;
      busy_out <= 1'b0;
      page_jump_out <= 1'b0;
      page_jump_page_out <= `RCRS_ROM_PAGE;
      page_jump_state_out <= 8'h00;
      decode_jump_out <= 1'b0;
    end else begin
      state <= next_state;
      mem_req_out <= `RCRS_REQ_NONE;
      page_jump_out <= 1'b0;
      decode_jump_out <= 1'b0;
      case (state)
        S_IDLE: begin
          busy_out <= 1'b0;
          if (hit_call) begin
            // decrement first, then store at the result
            stack_pointer_reg_out <= sp_dec;
            mem_addr_out <= sp_dec;
            mem_req_out <= `RCRS_REQ_OSTORE;
            alu_out <= linkage_reg_in;
            linkage_reg_out <= linkage_reg_in;
            pc_out <= pc_in;
            busy_out <= 1'b1;
          end else if (hit_ret) begin
            // restart pipeline at return address held in linkage
            mem_addr_out <= linkage_reg_in;
            mem_req_out <= `RCRS_REQ_IFETCH;
            pc_out <= linkage_reg_in;
            linkage_reg_out <= linkage_reg_in;
            stack_pointer_reg_out <= stack_pointer_reg_in;
            busy_out <= 1'b1;
          end
        end
        S_CALL_WAIT: begin
          // data and address stay put until the write completes
          alu_out <= alu_out;
        end
        S_CALL_LINK: begin
          // pc points at the address word; it already sits in memory_input_reg
          linkage_reg_out <= pc_plus;
          alu_out <= pc_plus;
          mem_addr_out <= memory_input_reg_in;
          mem_req_out <= `RCRS_REQ_IFETCH;
        end
        S_CALL_FETCH: begin
          pc_out <= mir_plus;
          alu_out <= mir_plus;
          mem_addr_out <= mir_plus;
          mem_req_out <= `RCRS_REQ_IFETCH;
          page_jump_out <= 1'b1;
          page_jump_page_out <= `RCRS_ROM_PAGE;
          page_jump_state_out <= `RCRS_DECODE_STATE;
        end
        S_RET_FETCH: begin
          // read at current pointer before any increment
          mem_addr_out <= stack_pointer_reg_out;
          mem_req_out <= `RCRS_REQ_OFETCH;
        end
        S_RET_STEP3: begin
          stack_pointer_reg_out <= sp_inc;
          pc_out <= pc_plus;
          mem_addr_out <= pc_plus;
          mem_req_out <= `RCRS_REQ_IFETCH;
        end
        S_RET_LOAD: begin
          // operand fetch must have landed; wait on completion
          if (mem_done) begin
            linkage_reg_out <= memory_input_reg_in;
            alu_out <= memory_input_reg_in;
            decode_jump_out <= 1'b1;
            page_jump_out <= 1'b1;
            page_jump_page_out <= `RCRS_ROM_PAGE;
          end
        end
        default: begin
          // a stray code drops back to idle with the sequencer released
          busy_out <= 1'b0;
        end
      endcase
    end
  end
endmodule // rcrs_sequencer

//--- core/rcrs_sync.v
`timescale 1ns/1ps
// two-stage synchroniser for a level from outside the clock domain
module rcrs_sync (
  // clock and reset
  input wire clk_in,
  input wire resetn_in,
  // level
  input wire d_in,
  output reg q_out
);
  reg stage1;

  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      stage1 <= 1'b0;
      q_out <= 1'b0;
    end else begin
      stage1 <= d_in;
      q_out <= stage1;
    end
  end
endmodule // rcrs_sync

//--- pkg/rcrs_map.vh
`ifndef RCRS_MAP_VH
`define RCRS_MAP_VH
// branch targets in the writable microstore
`define RCRS_CALL_PAGE 4'h1
`define RCRS_CALL_WORD 5'h01
`define RCRS_RET_PAGE 4'h1
`define RCRS_RET_WORD 5'h02
// page and state handed back to the central store
`define RCRS_ROM_PAGE 4'h0
`define RCRS_DECODE_STATE 8'h2D
// reset values
`define RCRS_SP_RESET 16'h0000
`define RCRS_LINK_RESET 16'h0000
`define RCRS_PC_RESET 16'h0000
// memory request codes
`define RCRS_REQ_NONE 2'h0
`define RCRS_REQ_IFETCH 2'h1
`define RCRS_REQ_OFETCH 2'h2
`define RCRS_REQ_OSTORE 2'h3
`endif

//--- tb/rcrs_mem_model.sv
`timescale 1ns/1ps
module rcrs_mem_model (
  // bus from the sequencer
  input wire logic clk_in,
  input wire logic [1:0] req_in,
  input wire logic [15:0] addr_in,
  input wire logic [15:0] data_in,
  // answer
  output logic done_out,
  output logic [15:0] mir_out
);
  logic [15:0] mem [logic [15:0]];
  int lat = 1;
  initial done_out = 1'b0;
  initial mir_out = 16'h0000;
  // only operand traffic answers; instruction fetches feed a buffer not modelled
  always @(posedge clk_in) begin : serve
    logic wr;
    logic [15:0] a;
    if (req_in[1]) begin
      wr = req_in[0];
      a = addr_in;
      repeat (lat) @(posedge clk_in);
      #1 done_out = 1'b1;
      if (wr) mem[a] = data_in;
      else mir_out = mem.exists(a) ? mem[a] : ~a;
      repeat (3) @(posedge clk_in);
      #1 done_out = 1'b0;
      @(posedge clk_in);
      // stale read data must not look valid
      #1 if (!wr) mir_out = ~mir_out;
    end
  end
endmodule // rcrs_mem_model

//--- tb/rcrs_sequencer_properties.sv
`timescale 1ns/1ps
module rcrs_sequencer_properties #(parameter WIDTH = 16) (
  // control
  input wire logic clk_in, resetn_in, bcs_valid_in, memory_done_in,
  input wire logic busy_out, page_jump_out, decode_jump_out,
  input wire logic [3:0] bcs_page_in, page_jump_page_out,
  input wire logic [4:0] bcs_word_in,
  input wire logic [7:0] page_jump_state_out,
  input wire logic [1:0] mem_req_out,
  // data
  input wire logic [WIDTH-1:0] pc_in, stack_pointer_reg_in, linkage_reg_in, memory_input_reg_in,
  input wire logic [WIDTH-1:0] mem_addr_out, alu_out, pc_out, stack_pointer_reg_out, linkage_reg_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  logic [WIDTH-1:0] pc_q;
  wire go = bcs_valid_in && !busy_out && bcs_page_in == 4'h1;
  // only idle dispatches are captured, so back-to-back calls go unchecked here
  always @(posedge clk_in) if (go) pc_q <= pc_in;
  chk_call_push: assert property (go && bcs_word_in == 5'h01 |=> mem_req_out == 2'h3
    && alu_out == $past(linkage_reg_in) && mem_addr_out == $past(stack_pointer_reg_in) - 1'b1
    && stack_pointer_reg_out == mem_addr_out) else $error("call push wrong");
  chk_store_stall: assert property (mem_req_out == 2'h3 ##1 !memory_done_in [*3]
    |-> mem_req_out == 2'h0 && $stable(alu_out)) else $error("store not stalled");
  chk_ret_steps: assert property (go && bcs_word_in == 5'h02 |=> mem_req_out == 2'h1
    && mem_addr_out == $past(linkage_reg_in) && pc_out == mem_addr_out
    ##1 mem_req_out == 2'h2 && mem_addr_out == $past(stack_pointer_reg_in, 2)
    ##1 mem_req_out == 2'h1 && stack_pointer_reg_out == $past(stack_pointer_reg_in, 3) + 1'b1
    && pc_out == $past(pc_out, 2) + 1'b1) else $error("return steps wrong");
  chk_call_end: assert property (page_jump_out && !decode_jump_out |-> mem_req_out == 2'h1
    && mem_addr_out == pc_out && $past(mem_req_out) == 2'h1 && pc_out == $past(mem_addr_out) + 1'b1
    && page_jump_page_out == 4'h0 && page_jump_state_out == 8'h2D) else $error("call end wrong");
  chk_link_save: assert property (page_jump_out && !decode_jump_out |->
    linkage_reg_out == pc_q + 1'b1) else $error("return address wrong");
  chk_ret_end: assert property (decode_jump_out |-> page_jump_out && page_jump_page_out == 4'h0
    && linkage_reg_out == $past(memory_input_reg_in)) else $error("return end wrong");
  chk_idle_quiet: assert property (!busy_out |-> mem_req_out == 2'h0 && !page_jump_out)
    else $error("activity while idle");
  chk_other_ignored: assert property (go && bcs_word_in != 5'h01 && bcs_word_in != 5'h02 |=>
    !busy_out) else $error("stray target taken");
  cov_call: cover property (page_jump_out && !decode_jump_out);
  cov_ret: cover property (decode_jump_out);
  cov_stall: cover property (mem_req_out == 2'h3 ##1 !memory_done_in [*3]);
endmodule // rcrs_sequencer_properties

//--- tb/rcrs_sequencer_tb.sv
`timescale 1ns/1ps
module rcrs_sequencer_tb;
  logic clk_in = 1'b0, resetn_in = 1'b0, bcs_valid_in = 1'b0;
  logic [3:0] bcs_page_in = 4'h0;
  logic [4:0] bcs_word_in = 5'h00;
  logic [15:0] pc_in = 16'h0000, stack_pointer_reg_in = 16'h0000, linkage_reg_in = 16'h0000, tgt, lk;
  wire memory_done_in, page_jump_out, decode_jump_out, busy_out;
  wire [1:0] mem_req_out;
  wire [3:0] page_jump_page_out;
  wire [7:0] page_jump_state_out;
  wire [15:0] memory_input_reg_in, mem_addr_out, alu_out, pc_out, stack_pointer_reg_out, linkage_reg_out;
  int error_cnt = 0, n_tests = 0;
  always #5 clk_in = ~clk_in;
  rcrs_sequencer #(.WIDTH(16)) dut_u (.*);
  rcrs_mem_model mem_u (.clk_in(clk_in), .req_in(mem_req_out), .addr_in(mem_addr_out), .data_in(alu_out),
    .done_out(memory_done_in), .mir_out(memory_input_reg_in));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // gap lets the memory model finish its previous answer
  task automatic run(input logic [4:0] word);
    repeat (4) @(posedge clk_in);
    #1 bcs_page_in = 4'h1;
    bcs_word_in = word;
    bcs_valid_in = 1'b1;
    @(posedge clk_in);
    #1 bcs_valid_in = 1'b0;
    repeat (60) begin
      if (page_jump_out === 1'b1) break;
      @(posedge clk_in);
      #1;
    end
  endtask
  initial begin
    void'($urandom(29));
    repeat (4) @(posedge clk_in);
    #1 resetn_in = 1'b1;
    run(5'h00);
    check(busy_out, 1'b0);
    for (int i = 0; i < 6; i++) begin
      pc_in = 16'($urandom);
      stack_pointer_reg_in = (i == 0) ? 16'h0000 : 16'($urandom);
      lk = 16'($urandom);
      linkage_reg_in = lk;
      tgt = 16'($urandom);
      mem_u.lat = $urandom_range(6);
      // let the model finish flipping its stale read data before planting the target
      repeat (6) @(posedge clk_in);
      #1 mem_u.mir_out = tgt;
      run(5'h01);
      check(page_jump_state_out, 16'h002D);
      check(page_jump_page_out, 16'h0000);
      check(pc_out, tgt + 16'h1);
      check(linkage_reg_out, pc_in + 16'h1);
      check(stack_pointer_reg_out, stack_pointer_reg_in - 16'h1);
      check(mem_u.mem[stack_pointer_reg_in - 16'h1], lk);
      linkage_reg_in = pc_in + 16'h1;
      stack_pointer_reg_in = stack_pointer_reg_in - 16'h1;
      run(5'h02);
      check(decode_jump_out, 1'b1);
      check(page_jump_page_out, 16'h0000);
      check(linkage_reg_out, lk);
      check(pc_out, linkage_reg_in + 16'h1);
      check(stack_pointer_reg_out, stack_pointer_reg_in + 16'h1);
    end
    test_done();
  end
  initial begin
    #50000;
    error_cnt++;
    test_done();
  end
endmodule // rcrs_sequencer_tb
bind rcrs_sequencer rcrs_sequencer_properties #(.WIDTH(WIDTH)) chk_u (.*);
